// ### src/amc_top.sv
// Operation
// - Three reset sources: power-on, reset pin low, reset over the bus.
// - Any reset restores configuration, enters low power, waits for start.
// - Power-on hold lasts 500 us; bus ignored until released.
// - Command bytes 06h or 07h reset the device; no extra wait needed.
// - General-call software reset performs the same full reset.
// - Single-shot: one conversion per start, then analog off.
// - Single-shot: configuration write mid-conversion restarts one conversion.
// - Continuous: each finished result loads and next conversion starts.
// - Continuous start waits 28.5 oscillator periods before converting.
// - Continuous: configuration write mid-conversion restarts conversion.
// - Sleep command lets conversion finish, then powers analog down.
// - Asleep: configuration kept, commands accepted, no conversions.
// - Start while asleep wakes and converts per the mode bit.
// - Target only; the clock line is never driven.
// - Lines are only pulled low or released, never driven high.
// - Address is 100 plus two bits per strap, sixteen addresses.
// - Straps re-sampled between start and first address clock fall.
// - Data changes only while clock is low; one pulse per bit.
// - Device drives data on reads, controller on writes.
// - Commands act only when latched on the eighth clock fall.
// - Start is 0000100x, sleep is 0000001x, x ignored.
// - General call with write then byte 06h resets the device.
`timescale 1ns/1ps
`default_nettype none
module amc_top #(
  parameter int POR_LEN = amc_pkg::POR_CYCLES,
  parameter int CONV_LEN = amc_pkg::CONV_CYCLES
) (
  input wire logic CORE_CLK,  // Core clock, 25 MHz.
  input wire logic RST,  // Power-on reset, synchronous, active high.
  input wire logic RESET_N,  // Reset pin, active low.
  input wire logic SCL_IN,  // Serial clock line level.
  input wire logic SDA_IN,  // Serial data line level.
  output logic SDA_OUT,  // Serial data drive value, always low.
  output logic SDA_OE,  // Serial data pull-low enable.
  input wire logic STRAP_LOW,  // Lower address strap pin level.
  input wire logic STRAP_HIGH,  // Upper address strap pin level.
  output logic [6:0] DEV_ADDR,  // Decoded target address.
  output logic [7:0] CONFIG,  // Configuration register.
  output logic READY,  // Out of reset, bus accepted.
  output logic ANALOG_ON,  // Analog circuitry and oscillator enabled.
  output logic CONV_BUSY,  // Conversion in progress.
  output logic RESULT_LOAD  // Pulse: result moves to output buffer.
);
  localparam logic [amc_pkg::CNT_W-1:0] POR_LAST =
    amc_pkg::CNT_W'(POR_LEN - 1);
  localparam logic [amc_pkg::CNT_W-1:0] START_LAST =
    amc_pkg::CNT_W'(amc_pkg::START_DELAY_CYCLES - 1);
  localparam logic [amc_pkg::CNT_W-1:0] CONV_LAST =
    amc_pkg::CNT_W'(CONV_LEN - 1);

  // ----------------------------------------------------------------------
  // Input synchronisers and line events
  // ----------------------------------------------------------------------
  logic [4:0] in_s;
  amc_sync #(.W(5)) u_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .d({STRAP_HIGH, STRAP_LOW, RESET_N, SDA_IN, SCL_IN}),
    .q(in_s)
  );

  wire scl_s = in_s[0];
  wire sda_s = in_s[1];
  wire pin_n_s = in_s[2];
  wire [1:0] strap_s = in_s[4:3];

  logic scl_d_r;
  logic sda_d_r;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  wire start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;

  // ----------------------------------------------------------------------
  // Power-on hold
  // ----------------------------------------------------------------------
  logic [amc_pkg::CNT_W-1:0] por_cnt_r;
  logic por_done_r;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      por_cnt_r <= '0;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      por_cnt_r <= por_cnt_r + 1'b1;
      por_done_r <= (por_cnt_r == POR_LAST);
    end
  end

  // The bus is deaf while power-on or the pin holds the device in reset.
  wire hold_rst = RST | ~por_done_r | ~pin_n_s;

  // ----------------------------------------------------------------------
  // Address straps
  // ----------------------------------------------------------------------
  logic [1:0] idle_smp_r;
  logic [1:0] start_smp_r;
  logic [6:0] addr_r;
  logic [3:0] strap_code;
  amc_strap_dec u_strap (
    .idle_smp(idle_smp_r),
    .start_smp(start_smp_r),
    .fall_smp(strap_s),
    .code(strap_code)
  );

  logic [3:0] bit_cnt_r;
  amc_pkg::amc_bus_e bus_st_r;
  wire first_fall = (bus_st_r == amc_pkg::B_ADDR) && scl_fall &&
    (bit_cnt_r == 4'h0);

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      idle_smp_r <= '0;
      start_smp_r <= '0;
      addr_r <= {amc_pkg::ADDR_PREFIX, 4'h0};
    end else begin
      if (scl_s && sda_s) begin
        idle_smp_r <= strap_s;
      end
      if (start_ev) begin
        start_smp_r <= strap_s;
      end
      if (first_fall) begin
        addr_r <= {amc_pkg::ADDR_PREFIX, strap_code};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Serial target
  // ----------------------------------------------------------------------
  logic [7:0] shift_r;
  logic rw_r;
  logic gc_r;
  logic wreg_r;
  logic sda_oe_r;
  logic [7:0] cfg_r;
  amc_pkg::amc_cmd_s cmd_r;

  amc_pkg::amc_bus_e st_nxt;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_nxt;
  logic rw_nxt;
  logic gc_nxt;
  logic wreg_nxt;
  logic oe_nxt;
  amc_pkg::amc_cmd_s cmd_nxt;

  wire byte_done = scl_fall && (bit_cnt_r == amc_pkg::BYTE_BITS);
  wire own_hit = (shift_r[7:1] == addr_r);
  wire gc_hit = (shift_r[7:1] == amc_pkg::GC_ADDR) && !shift_r[0];

  always_comb begin
    st_nxt = bus_st_r;
    cnt_nxt = bit_cnt_r;
    sh_nxt = shift_r;
    rw_nxt = rw_r;
    gc_nxt = gc_r;
    wreg_nxt = wreg_r;
    oe_nxt = sda_oe_r;
    cmd_nxt = '0;
    if (start_ev) begin
      st_nxt = amc_pkg::B_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
      gc_nxt = 1'b0;
      wreg_nxt = 1'b0;
    end else if (stop_ev) begin
      st_nxt = amc_pkg::B_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (bus_st_r)
        amc_pkg::B_ADDR, amc_pkg::B_WRITE: begin
          if (scl_rise && bit_cnt_r < amc_pkg::BYTE_BITS) begin
            sh_nxt = {shift_r[6:0], sda_s};
            cnt_nxt = bit_cnt_r + 1'b1;
          end
          if (byte_done && bus_st_r == amc_pkg::B_ADDR) begin
            if (own_hit || gc_hit) begin
              st_nxt = amc_pkg::B_ACK;
              oe_nxt = 1'b1;
              rw_nxt = shift_r[0];
              gc_nxt = gc_hit;
            end else begin
              st_nxt = amc_pkg::B_SKIP;
            end
          end else if (byte_done) begin
            st_nxt = amc_pkg::B_ACK;
            oe_nxt = 1'b1;
            if (gc_r) begin
              cmd_nxt.reset = (shift_r == amc_pkg::GC_RESET);
              gc_nxt = 1'b0;
            end else if (wreg_r) begin
              cmd_nxt.cfg_wr = 1'b1;
              cmd_nxt.cfg_data = shift_r;
              wreg_nxt = 1'b0;
            end else begin
              cmd_nxt.reset = (shift_r[7:1] == amc_pkg::CMD_RESET);
              cmd_nxt.start = (shift_r[7:1] == amc_pkg::CMD_START);
              cmd_nxt.sleep = (shift_r[7:1] == amc_pkg::CMD_SLEEP);
              wreg_nxt = (shift_r[7:2] == amc_pkg::CMD_WREG);
            end
          end
        end
        amc_pkg::B_ACK: begin
          if (scl_fall) begin
            cnt_nxt = 4'h0;
            if (rw_r) begin
              st_nxt = amc_pkg::B_READ;
              sh_nxt = cfg_r;
              oe_nxt = ~cfg_r[7];
            end else begin
              st_nxt = amc_pkg::B_WRITE;
              oe_nxt = 1'b0;
            end
          end
        end
        amc_pkg::B_READ: begin
          if (scl_rise) begin
            cnt_nxt = bit_cnt_r + 1'b1;
          end
          if (byte_done) begin
            st_nxt = amc_pkg::B_RACK;
            oe_nxt = 1'b0;
          end else if (scl_fall) begin
            sh_nxt = {shift_r[6:0], 1'b0};
            oe_nxt = ~shift_r[6];
          end
        end
        amc_pkg::B_RACK: begin
          if (scl_rise && sda_s) begin
            st_nxt = amc_pkg::B_SKIP;
          end else if (scl_fall) begin
            st_nxt = amc_pkg::B_READ;
            cnt_nxt = 4'h0;
            sh_nxt = cfg_r;
            oe_nxt = ~cfg_r[7];
          end
        end
        amc_pkg::B_SKIP: begin
          oe_nxt = 1'b0;
        end
        default: begin
          st_nxt = amc_pkg::B_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (hold_rst) begin
      bus_st_r <= amc_pkg::B_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      gc_r <= 1'b0;
      wreg_r <= 1'b0;
      sda_oe_r <= 1'b0;
      cmd_r <= '0;
    end else begin
      bus_st_r <= st_nxt;
      bit_cnt_r <= cnt_nxt;
      shift_r <= sh_nxt;
      rw_r <= rw_nxt;
      gc_r <= gc_nxt;
      wreg_r <= wreg_nxt;
      sda_oe_r <= oe_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion mode control
  // ----------------------------------------------------------------------
  amc_pkg::amc_mode_e mode_r;
  amc_pkg::amc_mode_e mode_nxt;
  logic [amc_pkg::CNT_W-1:0] conv_cnt_r;
  logic [amc_pkg::CNT_W-1:0] conv_cnt_nxt;
  logic sleep_pend_r;
  logic sleep_pend_nxt;
  logic [7:0] cfg_nxt;
  logic load_nxt;

  wire cont_mode = cfg_r[amc_pkg::CFG_CM_BIT];
  // A reset command empties the pipe through this term in the next cycle.
  wire mode_rst = hold_rst | cmd_r.reset;

  always_comb begin
    mode_nxt = mode_r;
    conv_cnt_nxt = conv_cnt_r + 1'b1;
    sleep_pend_nxt = sleep_pend_r;
    cfg_nxt = cfg_r;
    load_nxt = 1'b0;
    if (cmd_r.cfg_wr) begin
      cfg_nxt = cmd_r.cfg_data;
    end
    if (cmd_r.sleep && mode_r != amc_pkg::M_SLEEP) begin
      sleep_pend_nxt = 1'b1;
    end
    if (cmd_r.start) begin
      sleep_pend_nxt = 1'b0;
      conv_cnt_nxt = '0;
      // Continuous runs always pass the start delay, single shots do not.
      mode_nxt = cont_mode ? amc_pkg::M_DELAY : amc_pkg::M_CONV;
    end else begin
      case (mode_r)
        amc_pkg::M_SLEEP: begin
          conv_cnt_nxt = '0;
        end
        amc_pkg::M_DELAY: begin
          if (conv_cnt_r == START_LAST) begin
            mode_nxt = amc_pkg::M_CONV;
            conv_cnt_nxt = '0;
          end
        end
        amc_pkg::M_CONV: begin
          if (cmd_r.cfg_wr) begin
            conv_cnt_nxt = '0;  // and
          end else if (conv_cnt_r == CONV_LAST) begin
            load_nxt = 1'b1;
            conv_cnt_nxt = '0;
            if (!cont_mode || sleep_pend_r) begin
              mode_nxt = amc_pkg::M_SLEEP;
              sleep_pend_nxt = 1'b0;
            end
          end
        end
        default: begin
          mode_nxt = amc_pkg::M_SLEEP;
        end
      endcase
    end
  end

  // The pin clears mode state at once; release is seen through the
  // synchroniser, so the state stays cleared until the bus wakes too.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_r <= amc_pkg::M_SLEEP;
      conv_cnt_r <= '0;
      sleep_pend_r <= 1'b0;
      cfg_r <= amc_pkg::CFG_RESET;
      RESULT_LOAD <= 1'b0;
      ANALOG_ON <= 1'b0;
      CONV_BUSY <= 1'b0;
    end else if (mode_rst) begin
      mode_r <= amc_pkg::M_SLEEP;
      conv_cnt_r <= '0;
      sleep_pend_r <= 1'b0;
      cfg_r <= amc_pkg::CFG_RESET;
      RESULT_LOAD <= 1'b0;
      ANALOG_ON <= 1'b0;
      CONV_BUSY <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      conv_cnt_r <= conv_cnt_nxt;
      sleep_pend_r <= sleep_pend_nxt;
      cfg_r <= cfg_nxt;
      RESULT_LOAD <= load_nxt;
      ANALOG_ON <= (mode_nxt != amc_pkg::M_SLEEP);
      CONV_BUSY <= (mode_nxt == amc_pkg::M_CONV);
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      READY <= 1'b0;
      DEV_ADDR <= {amc_pkg::ADDR_PREFIX, 4'h0};
    end else begin
      READY <= ~hold_rst;
      DEV_ADDR <= addr_r;
    end
  end

  // Open drain: the line is only ever pulled low or let go, and no clock
  // drive exists at all.
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_oe_r;
  assign CONFIG = cfg_r;
endmodule // amc_top
`default_nettype wire

// ### src/amc_pkg.sv
`default_nettype none
package amc_pkg;

  // ----------------------------------------------------------------------
  // Clocks and timing
  // ----------------------------------------------------------------------
  localparam int CORE_HZ = 25000000;
  localparam int OSC_HZ = 1024000;
  localparam int POR_US = 500;
  localparam int POR_CYCLES = POR_US * (CORE_HZ / 1000000);
  // Start delay is 28.5 oscillator periods, kept as 57 half periods.
  localparam int START_HALF_OSC = 57;
  localparam int START_DELAY_CYCLES =
    (START_HALF_OSC * (CORE_HZ / 1000) + 2 * (OSC_HZ / 1000) - 1)
    / (2 * (OSC_HZ / 1000));
  localparam int CONV_OSC_PERIODS = 1036;
  localparam int CONV_CYCLES =
    (CONV_OSC_PERIODS * (CORE_HZ / 1000) + (OSC_HZ / 1000) - 1)
    / (OSC_HZ / 1000);
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------------
  localparam logic [2:0] ADDR_PREFIX = 3'h4;
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [7:0] GC_RESET = 8'h06;
  localparam logic [6:0] CMD_RESET = 7'h03;
  localparam logic [6:0] CMD_START = 7'h04;
  localparam logic [6:0] CMD_SLEEP = 7'h01;
  localparam logic [5:0] CMD_WREG = 6'h10;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ----------------------------------------------------------------------
  // Configuration register and straps
  // ----------------------------------------------------------------------
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CFG_CM_BIT = 1;
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_SUPPLY = 2'h1;
  localparam logic [1:0] STRAP_SDA = 2'h2;
  localparam logic [1:0] STRAP_SCL = 2'h3;

  typedef enum logic [2:0] {
    B_IDLE, B_ADDR, B_ACK, B_WRITE, B_READ, B_RACK, B_SKIP
  } amc_bus_e;

  typedef enum logic [1:0] {M_SLEEP, M_DELAY, M_CONV} amc_mode_e;

  typedef struct packed {
    logic start;
    logic sleep;
    logic reset;
    logic cfg_wr;
    logic [7:0] cfg_data;
  } amc_cmd_s;

endpackage
`default_nettype wire

// ### src/amc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module amc_sync #(
  parameter int W = 1
) (
  input wire logic clk,  // Sampling clock.
  input wire logic rst,  // Synchronous reset, active high.
  input wire logic [W-1:0] d,  // Asynchronous inputs.
  output logic [W-1:0] q  // Synchronised outputs.
);
  logic [W-1:0] meta_r;

  // Reset to high: bus lines idle high behind their pull-ups.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '1;
      q <= '1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // amc_sync
`default_nettype wire

// ### src/amc_strap_dec.sv
`timescale 1ns/1ps
`default_nettype none
module amc_strap_dec (
  input wire logic [1:0] idle_smp,  // Straps with both lines high.
  input wire logic [1:0] start_smp,  // Straps at the start condition.
  input wire logic [1:0] fall_smp,  // Straps at the first clock fall.
  output logic [3:0] code  // Address bits, high strap first.
);
  // Three samples (1,1), (0,1), (0,0) of (data, clock) tell the four
  // connections apart: a strap tied to a line copies that line.
  for (genvar i = 0; i < 2; i++) begin : g_strap
    wire [2:0] smp = {idle_smp[i], start_smp[i], fall_smp[i]};
    assign code[2*i+1:2*i] =
      (smp == 3'h7) ? amc_pkg::STRAP_SUPPLY :
      (smp == 3'h4) ? amc_pkg::STRAP_SDA :
      (smp == 3'h6) ? amc_pkg::STRAP_SCL : amc_pkg::STRAP_GND;
  end
endmodule // amc_strap_dec
`default_nettype wire

// ### sim/amc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module amc_checker #(
  parameter int POR_LEN = 20,
  parameter int CONV_LEN = 50
) (
  input wire logic CORE_CLK,  // Clock.
  input wire logic RST,  // Power-on reset.
  input wire logic RESET_N,  // Pin reset.
  input wire logic SCL_IN,  // Clock line.
  input wire logic SDA_OUT,  // Drive value.
  input wire logic SDA_OE,  // Pull enable.
  input wire logic [7:0] CONFIG,  // Configuration.
  input wire logic READY,  // Ready.
  input wire logic ANALOG_ON,  // Analog on.
  input wire logic CONV_BUSY,  // Converting.
  input wire logic RESULT_LOAD  // Result pulse.
);
  localparam int DLY_LO = 690;
  localparam int DLY_HI = 698;
  logic [15:0] por_cnt_r;
  logic [15:0] busy_cnt_r;
  logic [15:0] dly_cnt_r;
  logic [7:0] cfg_last_r;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  // ----------------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------------
  // Counters hold the long figures that a repetition cannot unroll.
  always_ff @(posedge CORE_CLK) begin
    cfg_last_r <= CONFIG;
    if (RST) begin
      por_cnt_r <= 16'h0000;
    end else if (por_cnt_r < 16'(POR_LEN + 7)) begin
      por_cnt_r <= por_cnt_r + 16'h0001;
    end
    if (!CONV_BUSY || RESULT_LOAD || CONFIG != cfg_last_r) begin
      busy_cnt_r <= 16'h0000;
    end else begin
      busy_cnt_r <= busy_cnt_r + 16'h0001;
    end
    if (!ANALOG_ON || CONV_BUSY) begin
      dly_cnt_r <= 16'h0000;
    end else begin
      dly_cnt_r <= dly_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  property p_out_low;
    SDA_OUT == 1'b0;
  endproperty
  a_out_low: assert property (p_out_low)
    else $error("Data line driven high.");
  property p_pin_clear;
    !RESET_N |-> CONFIG == amc_pkg::CFG_RESET && !ANALOG_ON && !CONV_BUSY;
  endproperty
  a_pin_clear: assert property (p_pin_clear)
    else $error("Pin reset did not clear state.");
  property p_por_hold;
    READY |-> por_cnt_r >= 16'(POR_LEN);
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("Ready before power-on hold ended.");
  property p_por_free;
    por_cnt_r == 16'(POR_LEN + 6) && RESET_N |-> READY;
  endproperty
  a_por_free: assert property (p_por_free)
    else $error("Power-on hold too long.");
  property p_quiet;
    (!READY) [*4] |-> !SDA_OE;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("Bus answered while held in reset.");
  property p_oe_edge;
    $changed(SDA_OE) |-> !SCL_IN;
  endproperty
  a_oe_edge: assert property (p_oe_edge)
    else $error("Data line moved while clock high.");
  property p_single_off;
    RESULT_LOAD && !CONFIG[amc_pkg::CFG_CM_BIT] |-> !CONV_BUSY && !ANALOG_ON;
  endproperty
  a_single_off: assert property (p_single_off)
    else $error("Single conversion did not power down.");
  property p_conv_len;
    RESULT_LOAD |-> busy_cnt_r inside {[CONV_LEN - 3:CONV_LEN + 3]};
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("Conversion length wrong.");
  property p_cont_delay;
    $rose(CONV_BUSY) && CONFIG[amc_pkg::CFG_CM_BIT]
      |-> dly_cnt_r inside {[DLY_LO:DLY_HI]};
  endproperty
  a_cont_delay: assert property (p_cont_delay)
    else $error("Continuous start delay wrong.");

  c_single: cover property (RESULT_LOAD && !CONFIG[amc_pkg::CFG_CM_BIT]);
  c_cont: cover property (RESULT_LOAD && CONFIG[amc_pkg::CFG_CM_BIT]);
  c_ack: cover property ($rose(SDA_OE));
endmodule  // amc_checker

bind amc_top amc_checker #(.POR_LEN(POR_LEN), .CONV_LEN(CONV_LEN)) u_chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .RESET_N(RESET_N), .SCL_IN(SCL_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .CONFIG(CONFIG), .READY(READY),
  .ANALOG_ON(ANALOG_ON), .CONV_BUSY(CONV_BUSY), .RESULT_LOAD(RESULT_LOAD)
);
`default_nettype wire

// ### sim/amc_master.sv
`timescale 1ns/1ps
`default_nettype none
module amc_master (
  input wire logic clk,  // Bench clock.
  input wire logic sda,  // Resolved data line.
  output logic scl_low,  // Pulls the clock line low.
  output logic sda_low  // Pulls the data line low.
);
  // Last byte seen on the data line, so that read data can be checked.
  logic [7:0] rx_byte;

  // Lines are only pulled low or let go; pull-ups make the high level.
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // No settling wait is kept after a reset command.
  task automatic start();
    @(posedge clk);
    sda_low <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Data moves only in the 5-cycle low phase; the high phase is 3 cycles.
  task automatic bit_io(input logic b, output logic smp);
    @(posedge clk);
    scl_low <= 1'b1;
    @(posedge clk);
    sda_low <= !b;
    repeat (4) @(posedge clk);
    scl_low <= 1'b0;
    repeat (2) @(posedge clk);
    smp = sda;
  endtask

  // The line is let go for the ninth bit so that the target can answer.
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
      rx_byte = {rx_byte[6:0], s};
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask

  task automatic stop();
    @(posedge clk);
    scl_low <= 1'b1;
    @(posedge clk);
    sda_low <= 1'b1;
    repeat (4) @(posedge clk);
    scl_low <= 1'b0;
    repeat (3) @(posedge clk);
    sda_low <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule  // amc_master
`default_nettype wire

// ### sim/amc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module amc_top_tb;
  localparam int CONV_N = 400;
  logic core_clk = 1'b0;
  logic rst;
  logic reset_n;
  logic [1:0] sel_lo;
  logic [1:0] sel_hi;
  logic m_scl_low;
  logic m_sda_low;
  logic sda_oe;
  logic sda_out;
  logic ready;
  logic analog_on;
  logic conv_busy;
  logic result_load;
  logic [6:0] dev_addr;
  logic [7:0] cfg;
  logic [7:0] exp_q[$];
  int err_total = 0;
  int tests_run = 0;
  int seed = 93;

  function automatic logic pick(input logic [1:0] s, input logic d,
                                input logic c);
    return (s == 2'h0) ? 1'b0 : (s == 2'h1) ? 1'b1 : (s == 2'h2) ? d : c;
  endfunction

  wire logic scl = !m_scl_low;
  wire logic sda = !(m_sda_low || (sda_oe && !sda_out));
  wire logic strap_lo = pick(sel_lo, sda, scl);
  wire logic strap_hi = pick(sel_hi, sda, scl);

  always #20 core_clk = !core_clk;

  amc_top #(.POR_LEN(20), .CONV_LEN(CONV_N)) uut (
    .CORE_CLK(core_clk), .RST(rst), .RESET_N(reset_n), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .STRAP_LOW(strap_lo),
    .STRAP_HIGH(strap_hi), .DEV_ADDR(dev_addr), .CONFIG(cfg), .READY(ready),
    .ANALOG_ON(analog_on), .CONV_BUSY(conv_busy), .RESULT_LOAD(result_load)
  );
  amc_master u_mst (
    .clk(core_clk), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low)
  );

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 200 && ready !== 1'b1; i++) begin
      @(posedge core_clk);
    end
    check({7'h00, ready}, 8'h01);
    repeat (4) @(posedge core_clk);
  endtask

  // Waits until every noted result has been seen, under a bound.
  task automatic drain();
    for (int i = 0; i < 4000 && exp_q.size() != 0; i++) begin
      @(posedge core_clk);
    end
    @(posedge core_clk);
    check({7'h00, exp_q.size() == 0}, 8'h01);
  endtask

  task automatic xact(input logic [6:0] a, input logic exp_ack, input int n,
                      input logic [7:0] b0, input logic [7:0] b1);
    logic k;
    u_mst.start();
    u_mst.send({a, 1'b0}, k);
    check({7'h00, k}, {7'h00, exp_ack});
    if (n > 0) begin
      u_mst.send(b0, k);
      check({7'h00, k}, 8'h01);
    end
    if (n > 1) begin
      u_mst.send(b1, k);
      check({7'h00, k}, 8'h01);
    end
    u_mst.stop();
  endtask

  // Reads the configuration byte back; the ninth bit must be let go.
  task automatic rd_cfg(input logic [7:0] exp);
    logic k;
    u_mst.start();
    u_mst.send(8'h81, k);
    check({7'h00, k}, 8'h01);
    u_mst.send(8'hFF, k);
    check(u_mst.rx_byte, exp);
    check({7'h00, k}, 8'h00);
    u_mst.stop();
  endtask

  // Each result pulse takes the oldest note; a pulse with none is an error.
  always @(posedge core_clk) begin
    if (result_load === 1'b1) begin
      if (exp_q.size() == 0) begin
        check({7'h00, result_load}, 8'h00);
      end else begin
        check(cfg, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    err_total++;
    results();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst <= 1'b1;
    reset_n <= 1'b1;
    sel_lo <= 2'h0;
    sel_hi <= 2'h0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    wait_ready();
    check(cfg, amc_pkg::CFG_RESET);
    check({7'h00, analog_on}, 8'h00);
    check({1'b0, dev_addr}, 8'h40);
    for (int k = 0; k < 8; k++) begin
      sel_hi <= 2'($random(seed));
      sel_lo <= 2'($random(seed));
      @(posedge core_clk);
      xact({3'h4, sel_hi, sel_lo} ^ {6'h00, k[0]}, !k[0], 0, 8'h00, 8'h00);
      check({1'b0, dev_addr}, {4'h4, sel_hi, sel_lo});
    end
    sel_hi <= 2'h0;
    sel_lo <= 2'h0;
    for (int k = 0; k < 2; k++) begin
      exp_q.push_back(8'h00);
      xact(7'h40, 1'b1, 1, 8'h08 | 8'(k), 8'h00);
      drain();
      check({6'h00, analog_on, conv_busy}, 8'h00);
    end
    exp_q.push_back(8'h10);
    xact(7'h40, 1'b1, 1, 8'h08, 8'h00);
    repeat (100) @(posedge core_clk);
    xact(7'h40, 1'b1, 2, 8'h40, 8'h10);
    drain();
    repeat (2 * CONV_N) @(posedge core_clk);
    for (int k = 0; k < 2; k++) begin
      xact(7'h40, 1'b1, 2, 8'h40, 8'h12);
      exp_q.push_back(8'h12);
      exp_q.push_back(8'h12);
      xact(7'h40, 1'b1, 1, 8'h08 | 8'(k), 8'h00);
      drain();
      exp_q.push_back(8'h12);
      xact(7'h40, 1'b1, 1, 8'h02 | 8'(k), 8'h00);
      drain();
      repeat (3 * CONV_N) @(posedge core_clk);
      check({6'h00, analog_on, conv_busy}, 8'h00);
      check(cfg, 8'h12);
      rd_cfg(8'h12);
    end
    for (int k = 0; k < 3; k++) begin
      xact(7'h40, 1'b1, 2, 8'h40, 8'h34);
      check(cfg, 8'h34);
      if (k < 2) xact(7'h40, 1'b1, 1, 8'h06 | 8'(k), 8'h00);
      else xact(7'h00, 1'b1, 1, amc_pkg::GC_RESET, 8'h00);
      repeat (4) @(posedge core_clk);
      check(cfg, amc_pkg::CFG_RESET);
    end
    xact(7'h40, 1'b1, 2, 8'h40, 8'h12);
    xact(7'h40, 1'b1, 1, 8'h08, 8'h00);
    repeat (50) @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(cfg, amc_pkg::CFG_RESET);
    check({6'h00, analog_on, conv_busy}, 8'h00);
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    wait_ready();
    xact(7'h40, 1'b1, 0, 8'h00, 8'h00);
    repeat (800) @(posedge core_clk);
    check({7'h00, analog_on}, 8'h00);
    results();
  end
endmodule  // amc_top_tb
`default_nettype wire
